// >>> seconds_watchdog_timer_tb.sv
module seconds_watchdog_timer_tb;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int TICKS = 20;

    logic        clk_sys = 1'b0;
    logic        rst = 1'b1;
    logic [15:0] s_axi_awaddr = 16'h0000;
    logic        s_axi_awvalid = 1'b0;
    logic        s_axi_awready;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic        s_axi_wvalid = 1'b0;
    logic        s_axi_wready;
    logic [1:0]  s_axi_bresp;
    logic        s_axi_bvalid;
    logic        s_axi_bready = 1'b0;
    logic [15:0] s_axi_araddr = 16'h0000;
    logic        s_axi_arvalid = 1'b0;
    logic        s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0]  s_axi_rresp;
    logic        s_axi_rvalid;
    logic        s_axi_rready = 1'b0;
    logic        nvmGuardOn = 1'b0;
    logic [7:0]  nvmExpirySeconds = 8'h05;
    logic        fwIrq;
    logic        expiryPinOutput;
    logic        irq;
    int          num_errors = 0;
    int          cmp_count = 0;
    logic [31:0] rdVal;
    logic [1:0]  resp;
    logic [7:0]  tmo;
    logic [7:0]  cause;
    logic [7:0]  preVal;
    int          n;

    always #2.5 clk_sys = ~clk_sys;

    swdt_top #(.TICK_CYCLES(TICKS)) swdt_top_inst (
        .clk_sys(clk_sys), .rst(rst),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .nvmGuardOn(nvmGuardOn),
        .nvmExpirySeconds(nvmExpirySeconds), .fwIrq(fwIrq),
        .expiryPinOutput(expiryPinOutput), .irq(irq)
    );

    task automatic finish_test();
        $display("errors %0d comparisons %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] expVal, input logic [31:0] got);
        cmp_count++;
        if (got !== expVal) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", what, expVal, got);
        end
    endtask

    task automatic hang(input string what);
        num_errors++;
        $display("[ERR] %s expected answer seen none", what);
        finish_test();
    endtask

    // address and data offered together, each dropped once taken
    task automatic axi_wr(input logic [15:0] a, input logic [31:0] d);
        logic awDone;
        logic wDone;
        int   k;
        awDone = 1'b0;
        wDone = 1'b0;
        @(posedge clk_sys);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (k = 0; k < 100; k++) begin
            @(posedge clk_sys);
            if (!awDone && s_axi_awready === 1'b1) begin
                awDone = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!wDone && s_axi_wready === 1'b1) begin
                wDone = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
            if (s_axi_bvalid === 1'b1) begin
                resp = s_axi_bresp;
                s_axi_bready <= 1'b0;
                return;
            end
        end
        hang("write response");
    endtask

    task automatic axi_rd(input logic [15:0] a);
        int k;
        @(posedge clk_sys);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (k = 0; k < 100; k++) begin
            @(posedge clk_sys);
            if (s_axi_arready === 1'b1 && s_axi_arvalid) begin
                s_axi_arvalid <= 1'b0;
            end
            if (s_axi_rvalid === 1'b1) begin
                rdVal = s_axi_rdata;
                resp = s_axi_rresp;
                s_axi_rready <= 1'b0;
                return;
            end
        end
        hang("read data");
    endtask

    function automatic logic [31:0] setupWord(logic [7:0] t, logic [7:0] c, logic p, logic g);
        return {t, c, 14'h0000, p, g};
    endfunction

    initial begin
        void'($urandom(32'hc576));
        repeat (12) @(posedge clk_sys);
        rst <= 1'b0;
        axi_rd(swdt_pkg::SETUP_OFS);
        chk("setup reset", setupWord(8'h05, 8'h05, 1'b0, 1'b0), rdVal);
        axi_rd(swdt_pkg::SWSTATUS_OFS);
        chk("status reset", 32'h0000_0000, rdVal);
        axi_rd(16'h1060);
        chk("unmapped read", {30'h0000_0000, swdt_pkg::RESP_SLVERR}, {rdVal[29:0], resp});
        axi_wr(16'h1064, 32'hffff_ffff);
        chk("unmapped write resp", swdt_pkg::RESP_SLVERR, resp);
        // short timeouts keep the run brief; never below two
        tmo = 8'($urandom_range(2, 4));
        axi_wr(swdt_pkg::SETUP_OFS, setupWord(tmo, 8'h00, 1'b0, 1'b1));
        chk("setup write resp", swdt_pkg::RESP_OKAY, resp);
        axi_wr(swdt_pkg::SWSTATUS_OFS, 32'h0000_0001);
        for (n = 0; n < (tmo + 2) * TICKS; n++) begin
            @(posedge clk_sys);
            if (fwIrq === 1'b1) break;
        end
        chk("expiry window", 1, n >= (tmo - 1) * TICKS && n <= tmo * TICKS + 4);
        chk("expiry pin", 1, expiryPinOutput);
        repeat (3 * TICKS) @(posedge clk_sys);
        axi_rd(swdt_pkg::SETUP_OFS);
        chk("count held zero", 8'h00, rdVal[23:16]);
        chk("irq stays", 2'b11, {fwIrq, expiryPinOutput});
        chk("masked irq", 0, irq);
        axi_wr(swdt_pkg::IRQ_MASK_OFS, 32'h0000_0003);
        chk("unmasked irq", 1, irq);
        axi_wr(swdt_pkg::IRQ_STATUS_OFS, 32'h0000_0003);
        axi_rd(swdt_pkg::IRQ_STATUS_OFS);
        chk("irq status cleared", 2'b00, rdVal[1:0]);
        chk("irq after clear", 0, irq);
        // guard off first: a free-running second could land between kick and readback
        axi_wr(swdt_pkg::SETUP_OFS, setupWord(tmo, 8'h00, 1'b0, 1'b0));
        axi_wr(swdt_pkg::SWSTATUS_OFS, 32'h0000_0001);
        chk("rearm clears pin", 2'b00, {fwIrq, expiryPinOutput});
        axi_rd(swdt_pkg::SETUP_OFS);
        chk("kick reload", tmo, rdVal[23:16]);
        axi_rd(swdt_pkg::SWSTATUS_OFS);
        chk("kick reads zero", 0, rdVal[0]);
        // guard off: count must freeze over several ticks
        axi_wr(swdt_pkg::SETUP_OFS, setupWord(tmo, 8'h00, 1'b0, 1'b0));
        repeat (3 * TICKS) @(posedge clk_sys);
        axi_rd(swdt_pkg::SETUP_OFS);
        chk("stopped count", setupWord(tmo, tmo, 1'b0, 1'b0), rdVal);
        preVal = 8'($urandom_range(8'h10, 8'hfe));
        axi_wr(swdt_pkg::SETUP_OFS, setupWord(tmo, preVal, 1'b1, 1'b0));
        axi_rd(swdt_pkg::SETUP_OFS);
        chk("preload count", preVal, rdVal[23:16]);
        axi_wr(swdt_pkg::SETUP_OFS, setupWord(tmo, 8'h07, 1'b0, 1'b0));
        axi_rd(swdt_pkg::SETUP_OFS);
        chk("count from timeout", tmo, rdVal[23:16]);
        cause = 8'($urandom_range(1, 255));
        axi_wr(swdt_pkg::SWSTATUS_OFS, {cause, 22'h00_0000, 2'b10});
        chk("forced expiry", 2'b11, {fwIrq, expiryPinOutput});
        chk("forced irq", 1, irq);
        axi_rd(swdt_pkg::SETUP_OFS);
        chk("forced count", 8'h00, rdVal[23:16]);
        axi_rd(swdt_pkg::SWSTATUS_OFS);
        chk("cause stored", {cause, 24'h00_0000}, rdVal);
        // second reset in mid-run, guard on and timeout taken from configuration
        nvmGuardOn <= 1'b1;
        nvmExpirySeconds <= 8'($urandom_range(2, 255));
        rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        axi_rd(swdt_pkg::SETUP_OFS);
        chk("setup second reset", setupWord(nvmExpirySeconds, nvmExpirySeconds, 1'b0, 1'b1), rdVal);
        chk("outputs second reset", 3'b000, {fwIrq, expiryPinOutput, irq});
        finish_test();
    end
endmodule

// >>> swdt_axil.sv
module swdt_axil (
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic [15:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [15:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    swdt_reg_if.bus          regs
);
    typedef struct packed {
        logic        awHave;
        logic        wHave;
        logic [15:0] addr;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } swdt_axil_t;

    swdt_axil_t q, d;

    assign s_axi_awready = !q.awHave && !q.bvalid;
    assign s_axi_wready  = !q.wHave && !q.bvalid;
    assign s_axi_arready = !q.rvalid;
    assign s_axi_bvalid  = q.bvalid;
    assign s_axi_bresp   = q.bresp;
    assign s_axi_rvalid  = q.rvalid;
    assign s_axi_rdata   = q.rdata;
    assign s_axi_rresp   = q.rresp;
    // write fires once both halves are held, one cycle before bvalid
    assign regs.wrEn     = q.awHave && q.wHave;
    assign regs.wrAddr   = q.addr;
    assign regs.wrData   = q.wdata;
    assign regs.wrStrb   = q.wstrb;
    assign regs.rdAddr   = s_axi_araddr;

    always_comb begin
        d = q;
        if (s_axi_awvalid && s_axi_awready) begin
            d.awHave = 1'b1;
            d.addr   = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            d.wHave = 1'b1;
            d.wdata = s_axi_wdata;
            d.wstrb = s_axi_wstrb;
        end
        if (regs.wrEn) begin
            d.awHave = 1'b0;
            d.wHave  = 1'b0;
            d.bvalid = 1'b1;
            d.bresp  = regs.wrHit ? swdt_pkg::RESP_OKAY : swdt_pkg::RESP_SLVERR;
        end
        if (q.bvalid && s_axi_bready) begin
            d.bvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            d.rvalid = 1'b1;
            d.rdata  = regs.rdData;
            d.rresp  = regs.rdHit ? swdt_pkg::RESP_OKAY : swdt_pkg::RESP_SLVERR;
        end else if (q.rvalid && s_axi_rready) begin
            d.rvalid = 1'b0;
        end
        if (rst) begin
            d = '0;
        end
    end

    always_ff @(posedge clk_sys) begin
        q <= d;
    end
endmodule

// >>> swdt_pkg.sv
package swdt_pkg;
    // register byte offsets
    localparam logic [15:0] SETUP_OFS      = 16'h1040;
    localparam logic [15:0] SWSTATUS_OFS   = 16'h1044;
    localparam logic [15:0] IRQ_STATUS_OFS = 16'h1050;
    localparam logic [15:0] IRQ_MASK_OFS   = 16'h1054;

    // watchdog_setup fields
    localparam int SETUP_GUARD_BIT   = 0;
    localparam int SETUP_PRELOAD_BIT = 1;
    localparam int SETUP_COUNT_LSB   = 16;
    localparam int SETUP_EXPIRY_LSB  = 24;

    // watchdog_software_status fields
    localparam int STS_KICK_BIT  = 0;
    localparam int STS_FORCE_BIT = 1;
    localparam int STS_CAUSE_LSB = 24;

    // interrupt status / mask layout
    localparam int IRQ_EXPIRY_BIT = 0;
    localparam int IRQ_FORCE_BIT  = 1;
    localparam int IRQ_WIDTH      = 2;

    // reset values not taken from configuration memory
    localparam logic [7:0] CAUSE_RST    = 8'h00;
    localparam logic [1:0] IRQ_MASK_RST = 2'h0;

    // one-second time base
    localparam int CLK_PERIOD_NS = 5;
    localparam int SECOND_NS     = 1000000000;
    localparam int TICK_CYCLES   = SECOND_NS / CLK_PERIOD_NS;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [0:0] {
        ST_RUN     = 1'b0,
        ST_EXPIRED = 1'b1
    } swdt_state_t;
endpackage

// >>> swdt_reg_if.sv
interface swdt_reg_if;
    logic        wrEn;
    logic [15:0] wrAddr;
    logic [31:0] wrData;
    logic [3:0]  wrStrb;
    logic        wrHit;
    logic [15:0] rdAddr;
    logic [31:0] rdData;
    logic        rdHit;

    modport bus  (output wrEn, wrAddr, wrData, wrStrb, rdAddr, input wrHit, rdData, rdHit);
    modport core (input wrEn, wrAddr, wrData, wrStrb, rdAddr, output wrHit, rdData, rdHit);
endinterface

// >>> swdt_tick.sv
module swdt_tick #(
    parameter int TICK_CYCLES = swdt_pkg::TICK_CYCLES
) (
    input  wire logic clk_sys,
    input  wire logic rst,
    output logic      tick
);
    typedef struct packed {
        logic [31:0] cnt;
        logic        tick;
    } swdt_tick_t;

    localparam logic [31:0] LAST = 32'(TICK_CYCLES - 1);

    swdt_tick_t q, d;

    assign tick = q.tick;

    // free running: a kick does not realign the second, so the first
    // decrement after a reload comes up to one second early
    always_comb begin
        d      = q;
        d.tick = 1'b0;
        if (q.cnt >= LAST) begin
            d.cnt  = 32'h0000_0000;
            d.tick = 1'b1;
        end else begin
            d.cnt = q.cnt + 32'h0000_0001;
        end
        if (rst) begin
            d = '0;
        end
    end

    always_ff @(posedge clk_sys) begin
        q <= d;
    end
endmodule

// >>> swdt_top.sv
// Function
// [RULE1] with preload permit set, a countdown write loads directly, else loads timeout
// [RULE2] countdown readable in bits 23:16, reloaded with timeout on every kick; a kick written with the force bit leaves it at zero
// [RULE3] on expiry raise firmware interrupt and assert expiry pin output
// [RULE4] after expiry countdown stays zero until software kicks again
// [RULE5] top byte of setup register sets timeout, one count per second
// [RULE6] software keeps timeout at two or more while the guard is on
// [RULE7] writing one to status bit zero re-arms; bit reads back zero
// [RULE8] writing one to force bit expires at once with countdown zero
// [RULE9] eight-bit fault cause stored for firmware; zero means healthy
// [RULE10] guard enable and timeout reset values come from configuration memory
// [RULE11] software writes countdown field only for debug and test use
// [RULE12] enabled and nonzero, count down once per second; disabled, stop
// [RULE13] expiry interrupt and pin stay asserted until software re-arms
module swdt_top #(
    parameter int TICK_CYCLES = swdt_pkg::TICK_CYCLES
) (
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic [15:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [15:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        nvmGuardOn,
    input  wire logic [7:0]  nvmExpirySeconds,
    output logic             fwIrq,
    output logic             expiryPinOutput,
    output logic             irq
);
    typedef struct packed {
        swdt_pkg::swdt_state_t state;
        logic                  expiryGuardOn;
        logic                  counterPreloadPermit;
        logic [7:0]            expirySeconds;
        logic [7:0]            countdownValue;
        logic [7:0]            faultCause;
        logic [1:0]            irqStatus;
        logic [1:0]            irqMask;
    } swdt_core_t;

    swdt_core_t q, d;
    swdt_reg_if regs ();
    logic       tick;

    swdt_axil u_axil (
        .clk_sys       (clk_sys),
        .rst           (rst),
        .s_axi_awaddr  (s_axi_awaddr),
        .s_axi_awvalid (s_axi_awvalid),
        .s_axi_awready (s_axi_awready),
        .s_axi_wdata   (s_axi_wdata),
        .s_axi_wstrb   (s_axi_wstrb),
        .s_axi_wvalid  (s_axi_wvalid),
        .s_axi_wready  (s_axi_wready),
        .s_axi_bresp   (s_axi_bresp),
        .s_axi_bvalid  (s_axi_bvalid),
        .s_axi_bready  (s_axi_bready),
        .s_axi_araddr  (s_axi_araddr),
        .s_axi_arvalid (s_axi_arvalid),
        .s_axi_arready (s_axi_arready),
        .s_axi_rdata   (s_axi_rdata),
        .s_axi_rresp   (s_axi_rresp),
        .s_axi_rvalid  (s_axi_rvalid),
        .s_axi_rready  (s_axi_rready),
        .regs          (regs)
    );

    swdt_tick #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_tick (
        .clk_sys (clk_sys),
        .rst     (rst),
        .tick    (tick)
    );

    function automatic logic isMapped(input logic [15:0] a);
        if (a == swdt_pkg::SETUP_OFS) begin
            return 1'b1;
        end else if (a == swdt_pkg::SWSTATUS_OFS) begin
            return 1'b1;
        end else if (a == swdt_pkg::IRQ_STATUS_OFS) begin
            return 1'b1;
        end else if (a == swdt_pkg::IRQ_MASK_OFS) begin
            return 1'b1;
        end else begin
            return 1'b0;
        end
    endfunction

    logic       setupWr;
    logic       statusWr;
    logic       kickWr;
    logic       forceWr;
    logic       countWr;
    logic       preloadNow;
    logic [1:0] irqSet;

    assign setupWr    = regs.wrEn && (regs.wrAddr == swdt_pkg::SETUP_OFS);
    assign statusWr   = regs.wrEn && (regs.wrAddr == swdt_pkg::SWSTATUS_OFS);
    assign kickWr     = statusWr && regs.wrStrb[0] && regs.wrData[swdt_pkg::STS_KICK_BIT];
    assign forceWr    = statusWr && regs.wrStrb[0] && regs.wrData[swdt_pkg::STS_FORCE_BIT];
    assign countWr    = setupWr && regs.wrStrb[2];
    // permit may come in the same write as the countdown byte
    assign preloadNow = q.counterPreloadPermit
                        || (regs.wrStrb[0] && regs.wrData[swdt_pkg::SETUP_PRELOAD_BIT]);

    assign regs.wrHit = isMapped(regs.wrAddr);
    assign regs.rdHit = isMapped(regs.rdAddr);

    always_comb begin
        regs.rdData = 32'h0000_0000;
        if (regs.rdAddr == swdt_pkg::SETUP_OFS) begin
            regs.rdData[swdt_pkg::SETUP_GUARD_BIT]   = q.expiryGuardOn;
            regs.rdData[swdt_pkg::SETUP_PRELOAD_BIT] = q.counterPreloadPermit;
            regs.rdData[swdt_pkg::SETUP_COUNT_LSB +: 8]  = q.countdownValue; // RULE2
            regs.rdData[swdt_pkg::SETUP_EXPIRY_LSB +: 8] = q.expirySeconds;
        end else if (regs.rdAddr == swdt_pkg::SWSTATUS_OFS) begin
            regs.rdData[swdt_pkg::STS_CAUSE_LSB +: 8] = q.faultCause; // RULE9
        end else if (regs.rdAddr == swdt_pkg::IRQ_STATUS_OFS) begin
            regs.rdData[swdt_pkg::IRQ_WIDTH-1:0] = q.irqStatus;
        end else if (regs.rdAddr == swdt_pkg::IRQ_MASK_OFS) begin
            regs.rdData[swdt_pkg::IRQ_WIDTH-1:0] = q.irqMask;
        end
    end

    always_comb begin
        d      = q;
        irqSet = 2'h0;
        // time base first; a kick or force write below overrides it, a countdown write only its decrement
        if (q.state == swdt_pkg::ST_RUN && q.expiryGuardOn) begin
            if (q.countdownValue == 8'h00) begin
                d.state = swdt_pkg::ST_EXPIRED; // RULE3
                irqSet[swdt_pkg::IRQ_EXPIRY_BIT] = 1'b1;
            end else if (tick) begin
                d.countdownValue = q.countdownValue - 8'h01; // RULE12
            end
        end
        if (setupWr) begin
            if (regs.wrStrb[0]) begin
                d.expiryGuardOn        = regs.wrData[swdt_pkg::SETUP_GUARD_BIT];
                d.counterPreloadPermit = regs.wrData[swdt_pkg::SETUP_PRELOAD_BIT];
            end
            if (regs.wrStrb[3]) begin
                d.expirySeconds = regs.wrData[swdt_pkg::SETUP_EXPIRY_LSB +: 8]; // RULE5
            end
            // an expired counter ignores countdown writes, only a kick frees it
            if (countWr && q.state == swdt_pkg::ST_RUN) begin
                if (preloadNow) begin
                    d.countdownValue = regs.wrData[swdt_pkg::SETUP_COUNT_LSB +: 8]; // RULE1
                end else begin
                    d.countdownValue = d.expirySeconds; // RULE1
                end
            end
            if (countWr) begin
                d.counterPreloadPermit = 1'b0; // RULE1
            end
        end
        if (statusWr && regs.wrStrb[3]) begin
            d.faultCause = regs.wrData[swdt_pkg::STS_CAUSE_LSB +: 8]; // RULE9
        end
        if (kickWr) begin
            d.state          = swdt_pkg::ST_RUN; // RULE7
            d.countdownValue = q.expirySeconds; // RULE2
            irqSet           = 2'h0;
        end
        // a fatal fault outranks a kick in the same write
        if (forceWr) begin
            d.state          = swdt_pkg::ST_EXPIRED; // RULE8
            d.countdownValue = 8'h00; // RULE8
            irqSet[swdt_pkg::IRQ_EXPIRY_BIT] = 1'b1;
            irqSet[swdt_pkg::IRQ_FORCE_BIT]  = 1'b1;
        end
        if (d.state == swdt_pkg::ST_EXPIRED) begin
            d.countdownValue = 8'h00; // RULE4
        end
        if (regs.wrEn && regs.wrAddr == swdt_pkg::IRQ_STATUS_OFS && regs.wrStrb[0]) begin
            d.irqStatus = q.irqStatus & ~regs.wrData[swdt_pkg::IRQ_WIDTH-1:0];
        end
        if (regs.wrEn && regs.wrAddr == swdt_pkg::IRQ_MASK_OFS && regs.wrStrb[0]) begin
            d.irqMask = regs.wrData[swdt_pkg::IRQ_WIDTH-1:0];
        end
        d.irqStatus = d.irqStatus | irqSet;
        if (rst) begin
            d.state                = swdt_pkg::ST_RUN;
            d.expiryGuardOn        = nvmGuardOn; // RULE10
            d.counterPreloadPermit = 1'b0;
            d.expirySeconds        = nvmExpirySeconds; // RULE10
            d.countdownValue       = nvmExpirySeconds; // RULE10
            d.faultCause           = swdt_pkg::CAUSE_RST;
            d.irqStatus            = 2'h0;
            d.irqMask              = swdt_pkg::IRQ_MASK_RST;
        end
    end

    always_ff @(posedge clk_sys) begin
        q <= d;
    end

    assign fwIrq           = (q.state == swdt_pkg::ST_EXPIRED); // RULE3
    assign expiryPinOutput = (q.state == swdt_pkg::ST_EXPIRED); // RULE13
    assign irq             = |(q.irqStatus & q.irqMask);

    property p_kick_reload;
        @(posedge clk_sys) disable iff (rst)
        (kickWr && !forceWr) |=> (q.countdownValue == $past(q.expirySeconds))
                                 && (q.state == swdt_pkg::ST_RUN);
    endproperty
    a_kick_reload: assert property (p_kick_reload) // RULE2
        else $error("kick did not reload countdown");

    property p_force_expire;
        @(posedge clk_sys) disable iff (rst)
        forceWr |=> fwIrq && expiryPinOutput && (q.countdownValue == 8'h00)
                    && q.irqStatus[swdt_pkg::IRQ_FORCE_BIT];
    endproperty
    a_force_expire: assert property (p_force_expire) // RULE8
        else $error("forced expiry not taken at once");

    property p_hold_zero;
        @(posedge clk_sys) disable iff (rst)
        (q.state == swdt_pkg::ST_EXPIRED && !kickWr) |=>
            (q.state == swdt_pkg::ST_EXPIRED) && (q.countdownValue == 8'h00);
    endproperty
    a_hold_zero: assert property (p_hold_zero) // RULE4
        else $error("expired countdown left zero without kick");

    property p_outputs_held;
        @(posedge clk_sys) disable iff (rst)
        (fwIrq && !kickWr) |=> fwIrq && expiryPinOutput;
    endproperty
    a_outputs_held: assert property (p_outputs_held) // RULE13
        else $error("expiry outputs dropped without re-arm");

    property p_expire_at_zero;
        @(posedge clk_sys) disable iff (rst)
        (q.state == swdt_pkg::ST_RUN && q.expiryGuardOn && q.countdownValue == 8'h00
         && !kickWr && !setupWr) |=> fwIrq ##0 expiryPinOutput
                                     ##0 q.irqStatus[swdt_pkg::IRQ_EXPIRY_BIT];
    endproperty
    a_expire_at_zero: assert property (p_expire_at_zero) // RULE3
        else $error("zero countdown did not expire");

    property p_decrement;
        @(posedge clk_sys) disable iff (rst)
        (tick && q.state == swdt_pkg::ST_RUN && q.expiryGuardOn
         && q.countdownValue != 8'h00 && !setupWr && !statusWr)
            |=> q.countdownValue == $past(q.countdownValue) - 8'h01;
    endproperty
    a_decrement: assert property (p_decrement) // RULE12
        else $error("countdown missed a second");

    property p_stopped;
        @(posedge clk_sys) disable iff (rst)
        (!q.expiryGuardOn && !setupWr && !statusWr) |=> $stable(q.countdownValue);
    endproperty
    a_stopped: assert property (p_stopped) // RULE12
        else $error("countdown moved while disabled");

    property p_only_on_tick;
        @(posedge clk_sys) disable iff (rst)
        (!tick && q.state == swdt_pkg::ST_RUN && q.countdownValue != 8'h00
         && !setupWr && !statusWr) |=> $stable(q.countdownValue);
    endproperty
    a_only_on_tick: assert property (p_only_on_tick) // RULE5
        else $error("countdown changed between seconds");

    property p_preload;
        @(posedge clk_sys) disable iff (rst)
        (countWr && preloadNow && q.state == swdt_pkg::ST_RUN && !statusWr) |=>
            (q.countdownValue == $past(regs.wrData[23:16])) && !q.counterPreloadPermit;
    endproperty
    a_preload: assert property (p_preload) // RULE1
        else $error("permitted countdown write not loaded");

    property p_timeout_load;
        @(posedge clk_sys) disable iff (rst)
        (countWr && !preloadNow && q.state == swdt_pkg::ST_RUN) |=>
            q.countdownValue == q.expirySeconds;
    endproperty
    a_timeout_load: assert property (p_timeout_load) // RULE1
        else $error("unpermitted countdown write not loaded from timeout");

    property p_cause;
        @(posedge clk_sys) disable iff (rst)
        (statusWr && regs.wrStrb[3]) |=> q.faultCause == $past(regs.wrData[31:24]);
    endproperty
    a_cause: assert property (p_cause) // RULE9
        else $error("fault cause not stored");

    property p_irq_level;
        @(posedge clk_sys) disable iff (rst)
        $rose(fwIrq) |-> ##[0:2] (irq || q.irqMask[swdt_pkg::IRQ_EXPIRY_BIT] == 1'b0);
    endproperty
    a_irq_level: assert property (p_irq_level) // RULE3
        else $error("unmasked expiry did not raise irq");
endmodule
